// ### hdl/csti_core_ctrl.sv
/*
 Processor status/control, timer read, interrupt latch and acknowledge.
 Assumes the core gives I/O strobes, instruction-end and opcode pulses.
*/
`timescale 1ns/1ps
`include "csti_defines.svh"
module csti_core_ctrl #(
    parameter int TICK_CYC = `CSTI_TICK_CYC,
    parameter int SE0_CYC = `CSTI_SE0_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wdt_rst_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic instr_last_i,
    input wire logic halt_instr_i,
    input wire logic disable_irq_instruction_i,
    input wire logic enable_irq_instruction_i,
    input wire logic return_from_irq_instruction_i,
    input wire logic usb_dp_i,
    input wire logic usb_dm_i,
    input wire logic bus_activity_i,
    input wire logic [2:0] endpoint_evt_i,
    input wire logic dac_evt_i,
    input wire logic gpio_evt_i,
    output logic run_o,
    output logic suspend_o,
    output logic wake_long_o,
    output logic irq_call_o,
    output logic [15:0] irq_vector_o,
    output logic irq_restore_o
);
    typedef struct packed {
        logic [7:0] psc;
        logic [7:0] glb_ien;
        logic [2:0] ep_ien;
        logic [7:0] latch;
        logic [3:0] hold;
        logic [7:0] rdata;
        logic [15:0] se0_cnt;
        logic se0_seen;
        logic [2:0] sel;
        csti_pkg::csti_ack_t ack;
        logic call;
        logic [15:0] vec;
        logic restore;
        logic wdt_seen;
    } state_t;

    state_t st, next_st;
    logic [11:0] tmr_count;
    logic tick_128;
    logic tick_1024;
    logic [7:0] src_evt;
    logic [7:0] src_en;
    logic [7:0] active;
    logic [2:0] pick;
    logic se0_long;
    logic irq_any;
    logic susp_ok;
    logic [15:0] vec_tab [`CSTI_NUM_SRC];

    csti_timer #(.TICK_CYC(TICK_CYC)) u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .count_o(tmr_count),
        .tick_128_o(tick_128),
        .tick_1024_o(tick_1024)
    );

    assign vec_tab[0] = `CSTI_VEC_BUSRST;
    assign vec_tab[1] = `CSTI_VEC_T128;
    assign vec_tab[2] = `CSTI_VEC_T1024;
    assign vec_tab[3] = `CSTI_VEC_EP0;
    assign vec_tab[4] = `CSTI_VEC_EP1;
    assign vec_tab[5] = `CSTI_VEC_EP2;
    assign vec_tab[6] = `CSTI_VEC_DAC;
    assign vec_tab[7] = `CSTI_VEC_GPIO;

    // Shared conditions
    assign se0_long = (st.se0_cnt == 16'(SE0_CYC)) && !st.se0_seen;
    assign irq_any = (active != 8'h00);
    assign susp_ok = !bus_activity_i && !irq_any && !st.psc[`CSTI_BIT_IRQP];

    always_comb begin
        src_evt = {gpio_evt_i, dac_evt_i, endpoint_evt_i, tick_1024, tick_128, 1'b0};
        src_evt[0] = 1'b0;
        // Bus reset, timers, endpoints, converter, pins
        src_en = {st.glb_ien[6:5], st.ep_ien, st.glb_ien[2:0]};
    end

    // Per-source enable gating and lowest-index priority pick
    genvar gi;
    generate
        for (gi = 0; gi < `CSTI_NUM_SRC; gi++) begin : g_src
            assign active[gi] = st.latch[gi] & src_en[gi];
        end
    endgenerate

    always_comb begin
        pick = 3'h0;
        for (int i = `CSTI_NUM_SRC - 1; i >= 0; i--) begin
            if (active[i]) begin
                pick = 3'(i);
            end
        end
    end

    always_comb begin
        next_st = st;
        next_st.call = 1'b0;
        next_st.restore = 1'b0;
        next_st.wdt_seen = 1'b0;
        // Bus reset detect
        if (!usb_dp_i && !usb_dm_i) begin
            if (st.se0_cnt != 16'(SE0_CYC)) begin
                next_st.se0_cnt = st.se0_cnt + 16'h0001;
            end
        end else begin
            next_st.se0_cnt = 16'h0000;
            next_st.se0_seen = 1'b0;
        end

        // Register reads
        if (io_rd_i) begin
            case (io_addr_i)
                `CSTI_ADDR_TMR_LO: begin
                    next_st.rdata = tmr_count[7:0];
                    next_st.hold = tmr_count[11:8];
                end
                `CSTI_ADDR_TMR_HI: begin
                    next_st.rdata = {4'h0, st.hold};
                end
                `CSTI_ADDR_EP_IEN: begin
                    next_st.rdata = {5'h00, st.ep_ien};
                end
                `CSTI_ADDR_GLB_IEN: begin
                    next_st.rdata = st.glb_ien;
                end
                `CSTI_ADDR_PSC: begin
                    next_st.rdata = st.psc;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // Register writes
        if (io_wr_i) begin
            case (io_addr_i)
                `CSTI_ADDR_EP_IEN: begin
                    next_st.ep_ien = io_wdata_i[2:0];
                end
                `CSTI_ADDR_GLB_IEN: begin
                    next_st.glb_ien = io_wdata_i & 8'h67;
                end
                `CSTI_ADDR_PSC: begin
                    next_st.psc[`CSTI_BIT_RUN] = io_wdata_i[`CSTI_BIT_RUN];
                    next_st.psc[`CSTI_BIT_STEP] = io_wdata_i[`CSTI_BIT_STEP];
                    next_st.psc[`CSTI_BIT_POR] = io_wdata_i[`CSTI_BIT_POR];
                    next_st.psc[`CSTI_BIT_BUSRST] = io_wdata_i[`CSTI_BIT_BUSRST];
                    next_st.psc[`CSTI_BIT_WDR] = io_wdata_i[`CSTI_BIT_WDR];
                    if (io_wdata_i[`CSTI_BIT_SUSP] && susp_ok) begin
                        next_st.psc[`CSTI_BIT_SUSP] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Suspend wake
        if (st.psc[`CSTI_BIT_SUSP] && (bus_activity_i || irq_any)) begin
            next_st.psc[`CSTI_BIT_SUSP] = 1'b0;
        end

        // Long SE0 sets flag once per event
        if (se0_long) begin
            next_st.se0_seen = 1'b1;
            next_st.psc[`CSTI_BIT_BUSRST] = 1'b1;
        end

        // Latch events; set beats ack clear
        for (int i = 0; i < `CSTI_NUM_SRC; i++) begin
            if (st.ack == csti_pkg::ACK_CLR && st.sel == 3'(i)) begin
                next_st.latch[i] = 1'b0;
            end
        end
        next_st.latch = next_st.latch | src_evt;
        if (se0_long) begin
            next_st.latch[0] = 1'b1;
        end

        // Halt and single step
        if (instr_last_i && st.psc[`CSTI_BIT_RUN]) begin
            if (halt_instr_i || st.psc[`CSTI_BIT_STEP]) begin
                next_st.psc[`CSTI_BIT_RUN] = 1'b0;
            end
        end

        // Global mask from instructions
        if (disable_irq_instruction_i) begin
            next_st.psc[`CSTI_BIT_IMASK] = 1'b0;
        end
        if (enable_irq_instruction_i) begin
            next_st.psc[`CSTI_BIT_IMASK] = 1'b1;
        end
        if (return_from_irq_instruction_i) begin
            next_st.psc[`CSTI_BIT_IMASK] = 1'b1;
            next_st.restore = 1'b1;
        end

        // Acknowledge sequence
        case (st.ack)
            csti_pkg::ACK_IDLE: begin
                if (instr_last_i && st.psc[`CSTI_BIT_IMASK] && irq_any) begin
                    next_st.sel = pick;
                    next_st.psc[`CSTI_BIT_IRQP] = 1'b1;
                    next_st.ack = csti_pkg::ACK_MASK;
                end
            end
            csti_pkg::ACK_MASK: begin
                next_st.psc[`CSTI_BIT_IMASK] = 1'b0;
                next_st.ack = csti_pkg::ACK_CLR;
            end
            csti_pkg::ACK_CLR: begin
                next_st.psc[`CSTI_BIT_IRQP] = 1'b0;
                next_st.ack = csti_pkg::ACK_CALL;
            end
            csti_pkg::ACK_CALL: begin
                next_st.call = 1'b1;
                next_st.vec = vec_tab[st.sel];
                next_st.ack = csti_pkg::ACK_IDLE;
            end
            default: begin
                next_st.ack = csti_pkg::ACK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.psc <= `CSTI_PSC_POR;
            st.ack <= csti_pkg::ACK_IDLE;
        end else if (wdt_rst_i) begin
            st <= '0;
            st.psc <= `CSTI_PSC_WDR;
            st.ack <= csti_pkg::ACK_IDLE;
            st.wdt_seen <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign io_rdata_o = st.rdata;
    assign run_o = st.psc[`CSTI_BIT_RUN];
    assign suspend_o = st.psc[`CSTI_BIT_SUSP];
    assign wake_long_o = st.psc[`CSTI_BIT_POR];
    assign irq_call_o = st.call;
    assign irq_vector_o = st.vec;
    assign irq_restore_o = st.restore;
endmodule // csti_core_ctrl

// ### hdl/csti_defines.svh
/*
 Constants for the core status, timer and interrupt control block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CSTI_DEFINES_SVH
`define CSTI_DEFINES_SVH
`define CSTI_ADDR_EP_IEN 8'h21
`define CSTI_ADDR_GLB_IEN 8'h20
`define CSTI_ADDR_TMR_LO 8'h24
`define CSTI_ADDR_TMR_HI 8'h25
`define CSTI_ADDR_PSC 8'hFF
`define CSTI_PSC_POR 8'h11
`define CSTI_PSC_WDR 8'h41
`define CSTI_BIT_RUN 0
`define CSTI_BIT_STEP 1
`define CSTI_BIT_IMASK 2
`define CSTI_BIT_SUSP 3
`define CSTI_BIT_POR 4
`define CSTI_BIT_BUSRST 5
`define CSTI_BIT_WDR 6
`define CSTI_BIT_IRQP 7
`define CSTI_CLK_MHZ 50
`define CSTI_TICK_NS 1000
`define CSTI_TICK_CYC ((`CSTI_TICK_NS * `CSTI_CLK_MHZ) / 1000)
`define CSTI_SE0_NS 8000
`define CSTI_SE0_CYC (((`CSTI_SE0_NS * `CSTI_CLK_MHZ) / 1000) + 1)
`define CSTI_WAKE_SHORT_US 128
`define CSTI_WAKE_LONG_US 96000
`define CSTI_NUM_SRC 8
`define CSTI_VEC_BUSRST 16'h0002
`define CSTI_VEC_T128 16'h0004
`define CSTI_VEC_T1024 16'h0006
`define CSTI_VEC_EP0 16'h0008
`define CSTI_VEC_EP1 16'h000A
`define CSTI_VEC_EP2 16'h000C
`define CSTI_VEC_DAC 16'h0014
`define CSTI_VEC_GPIO 16'h0016
`endif

// ### hdl/csti_pkg.sv
/*
 Types for the core status, timer and interrupt control block.
 Assumes the defines header is compiled alongside.
*/
package csti_pkg;
    typedef enum logic [3:0] {
        ACK_IDLE = 4'h1,
        ACK_MASK = 4'h2,
        ACK_CLR = 4'h4,
        ACK_CALL = 4'h8
    } csti_ack_t;
    typedef struct packed {
        logic [11:0] count;
        logic [15:0] presc;
    } csti_tmr_t;
endpackage

// ### hdl/csti_timer.sv
/*
 Free-running 12-bit microsecond timer with 128 us and 1.024 ms ticks.
 Assumes one synchronous clock; no read strobe here, the core latches the count on reads.
*/
`timescale 1ns/1ps
`include "csti_defines.svh"
module csti_timer #(
    parameter int TICK_CYC = `CSTI_TICK_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    output logic [11:0] count_o,
    output logic tick_128_o,
    output logic tick_1024_o
);
    csti_pkg::csti_tmr_t st, next_st;
    always_comb begin
        next_st = st;
        if (st.presc == 16'(TICK_CYC - 1)) begin
            next_st.presc = 16'h0000;
            next_st.count = st.count + 12'h001;
        end else begin
            next_st.presc = st.presc + 16'h0001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign count_o = st.count;
    // Pulses when low bits roll over
    assign tick_128_o = (st.presc == 16'(TICK_CYC - 1)) && (st.count[6:0] == 7'h7F);
    assign tick_1024_o = (st.presc == 16'(TICK_CYC - 1)) && (st.count[9:0] == 10'h3FF);
endmodule // csti_timer

// ### tb/csti_core_ctrl_assertions.sv
/*
 Port checker for csti_core_ctrl, bound at the foot of this file.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module csti_chk #(
    parameter int TICK_CYC = 50,
    parameter int SE0_CYC = 401
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wdt_rst_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_addr_i,
    input wire logic instr_last_i,
    input wire logic halt_instr_i,
    input wire logic return_from_irq_instruction_i,
    input wire logic bus_activity_i,
    input wire logic run_o,
    input wire logic suspend_o,
    input wire logic wake_long_o,
    input wire logic irq_call_o,
    input wire logic [15:0] irq_vector_o,
    input wire logic irq_restore_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_por;
        $rose(rst_n_i) |-> run_o && wake_long_o && !suspend_o;
    endproperty
    a_por: assert property (p_por) else $error("Power-on state wrong");
    property p_wdt;
        wdt_rst_i |=> run_o && !wake_long_o && !suspend_o;
    endproperty
    a_wdt: assert property (p_wdt) else $error("Watchdog state wrong");
    property p_halt;
        halt_instr_i && instr_last_i && !wdt_rst_i |=> !run_o;
    endproperty
    a_halt: assert property (p_halt) else $error("Halt left run set");
    property p_susp;
        io_wr_i && io_addr_i == 8'hFF && bus_activity_i && !suspend_o && !wdt_rst_i
            |=> !suspend_o;
    endproperty
    a_susp: assert property (p_susp) else $error("Suspend taken with bus busy");
    property p_ret;
        return_from_irq_instruction_i && !wdt_rst_i |-> ##[1:2] irq_restore_o;
    endproperty
    a_ret: assert property (p_ret) else $error("No restore after return");
    property p_gap;
        irq_call_o |=> !irq_call_o [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("Calls too close");
    property p_vec;
        irq_call_o |-> irq_vector_o inside {16'h0002, 16'h0004, 16'h0006, 16'h0008,
            16'h000A, 16'h000C, 16'h0014, 16'h0016};
    endproperty
    a_vec: assert property (p_vec) else $error("Bad vector");
    property p_recog;
        irq_call_o |-> $past(instr_last_i, 4);
    endproperty
    a_recog: assert property (p_recog) else $error("Call not after last cycle");
endmodule // csti_chk

bind csti_core_ctrl csti_chk #(.TICK_CYC(TICK_CYC), .SE0_CYC(SE0_CYC)) u_chk (.*);

// ### tb/csti_tb.sv
/*
 Register-level bench for csti_core_ctrl.
 Assumes shortened tick and bus reset counts.
*/
`timescale 1ns/1ps
module tb;
    localparam int TK = 2;
    logic clk_sys_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic wdt_rst_i = 1'h0;
    logic io_wr_i = 1'h0;
    logic io_rd_i = 1'h0;
    logic [7:0] io_addr_i = 8'h00;
    logic [7:0] io_wdata_i = 8'h00;
    logic [7:0] io_rdata_o;
    logic instr_last_i = 1'h0;
    logic halt_instr_i = 1'h0;
    logic disable_irq_instruction_i = 1'h0;
    logic enable_irq_instruction_i = 1'h0;
    logic return_from_irq_instruction_i = 1'h0;
    logic usb_dp_i = 1'h0;
    logic usb_dm_i = 1'h1;
    logic bus_activity_i = 1'h0;
    logic [2:0] endpoint_evt_i = 3'h0;
    logic dac_evt_i = 1'h0;
    logic gpio_evt_i = 1'h0;
    logic run_o, suspend_o, wake_long_o, irq_call_o, irq_restore_o;
    logic [15:0] irq_vector_o;
    logic [7:0] rd, lo;
    logic [1:0] icnt = 2'h0;
    int bad_count = 0;
    int compares = 0;
    csti_core_ctrl #(.TICK_CYC(TK), .SE0_CYC(5)) DUT (.*);
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        icnt <= icnt + 2'h1;
        instr_last_i <= (icnt == 2'h3);
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        io_wr_i <= 1'h1;
        io_addr_i <= a;
        io_wdata_i <= d;
        @(posedge clk_sys_i);
        io_wr_i <= 1'h0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        io_rd_i <= 1'h1;
        io_addr_i <= a;
        @(posedge clk_sys_i);
        io_rd_i <= 1'h0;
        cyc(1);
        d = io_rdata_o;
    endtask
    task automatic wcall(input logic [15:0] v);
        int n = 0;
        while (irq_call_o !== 1'h1 && n < 2000) begin
            cyc(1);
            n++;
        end
        chk("call", 1'h1, irq_call_o);
        chk("vector", v, irq_vector_o);
    endtask
    task automatic end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        rdr(8'hFF, rd);
        chk("psc", 8'h11, rd);
        chk("wake_long", 1'h1, wake_long_o);
        rdr(8'h21, rd);
        chk("ep_ien", 8'h00, rd);
        rdr(8'h30, rd);
        chk("unmapped", 8'h00, rd);
        wr(8'h21, 8'h05);
        rdr(8'h21, rd);
        chk("ep_ien", 8'h05, rd);
        wr(8'hFF, 8'h15);
        rdr(8'hFF, rd);
        chk("psc", 8'h11, rd);
        rdr(8'h24, lo);
        repeat (10 * TK - 3) @(posedge clk_sys_i);
        rdr(8'h24, rd);
        chk("tmr_lo", 8'(lo + 8'h0A), rd);
        rdr(8'h25, lo);
        repeat (600 * TK) @(posedge clk_sys_i);
        rdr(8'h25, rd);
        chk("tmr_hi", {4'h0, lo[3:0]}, rd);
        wr(8'h20, 8'h03);
        usb_dm_i <= 1'h0;
        repeat (10) @(posedge clk_sys_i);
        usb_dm_i <= 1'h1;
        rdr(8'hFF, rd);
        chk("psc", 8'h31, rd);
        chk("run", 1'h1, run_o);
        @(posedge clk_sys_i);
        enable_irq_instruction_i <= 1'h1;
        @(posedge clk_sys_i);
        enable_irq_instruction_i <= 1'h0;
        wcall(16'h0002);
        rdr(8'hFF, rd);
        chk("psc_ack", 8'h00, rd & 8'h84);
        @(posedge clk_sys_i);
        return_from_irq_instruction_i <= 1'h1;
        @(posedge clk_sys_i);
        return_from_irq_instruction_i <= 1'h0;
        #1;
        chk("restore", 1'h1, irq_restore_o);
        wcall(16'h0004);
        wr(8'h20, 8'h00);
        @(posedge clk_sys_i);
        enable_irq_instruction_i <= 1'h1;
        @(posedge clk_sys_i);
        enable_irq_instruction_i <= 1'h0;
        rdr(8'hFF, rd);
        chk("imask", 8'h04, rd & 8'h04);
        @(posedge clk_sys_i);
        disable_irq_instruction_i <= 1'h1;
        @(posedge clk_sys_i);
        disable_irq_instruction_i <= 1'h0;
        rdr(8'hFF, rd);
        chk("imask", 8'h00, rd & 8'h04);
        bus_activity_i <= 1'h1;
        wr(8'hFF, 8'h19);
        cyc(2);
        chk("suspend", 1'h0, suspend_o);
        @(posedge clk_sys_i);
        bus_activity_i <= 1'h0;
        wr(8'hFF, 8'h19);
        cyc(2);
        chk("suspend", 1'h1, suspend_o);
        @(posedge clk_sys_i);
        bus_activity_i <= 1'h1;
        cyc(4);
        chk("suspend", 1'h0, suspend_o);
        @(posedge clk_sys_i);
        bus_activity_i <= 1'h0;
        wr(8'hFF, 8'h13);
        cyc(8);
        chk("run", 1'h0, run_o);
        @(posedge clk_sys_i);
        wdt_rst_i <= 1'h1;
        @(posedge clk_sys_i);
        wdt_rst_i <= 1'h0;
        rdr(8'hFF, rd);
        chk("psc", 8'h41, rd);
        chk("wake_long", 1'h0, wake_long_o);
        rdr(8'h21, rd);
        chk("ep_ien", 8'h00, rd);
        @(posedge clk_sys_i);
        halt_instr_i <= 1'h1;
        cyc(5);
        chk("run", 1'h0, run_o);
        @(posedge clk_sys_i);
        halt_instr_i <= 1'h0;
        rst_n_i <= 1'h0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        rdr(8'hFF, rd);
        chk("psc", 8'h11, rd);
        end_sim;
    end
endmodule // tb
